// File: design/sramc_pkg.sv
package sramc_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 100;

  // Device geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int WORD_COUNT = 262144;

  // Write timing, ns
  localparam int WRITE_PULSE_MIN_NS = 40;
  localparam int WRITE_CYCLE_MIN_NS = 55;
  localparam int ADDR_TO_WRITE_END_MIN_NS = 50;
  localparam int DATA_OVERLAP_MIN_NS = 25;
  localparam int ADDR_SETUP_MIN_NS = 0;
  localparam int POST_WRITE_DRIVE_MIN_NS = 5;
  localparam int WRITE_RELEASE_MAX_NS = 20;

  // Read timing, ns
  localparam int READ_CYCLE_MIN_NS = 55;
  localparam int ADDR_ACCESS_MAX_NS = 55;
  localparam int DRIVE_ENABLE_ACCESS_MAX_NS = 30;
  localparam int READ_HOLD_MIN_NS = 10;

  // Retention timing, ns
  localparam int DESELECT_TO_RETENTION_NS = 0;
  localparam int RETENTION_RECOVERY_NS = READ_CYCLE_MIN_NS;

  // Input synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Least time in whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Derived cycle counts
  localparam int WE_LOW_CYC = max2(cyc_up(WRITE_PULSE_MIN_NS), cyc_up(DATA_OVERLAP_MIN_NS));
  localparam int READ_ACCESS_CYC =
    max2(cyc_up(ADDR_ACCESS_MAX_NS), cyc_up(DRIVE_ENABLE_ACCESS_MAX_NS));
  localparam int READ_WAIT_CYC = READ_ACCESS_CYC + SYNC_STAGES;
  localparam int RECOVERY_CYC = cyc_up(RETENTION_RECOVERY_NS);

  localparam int CNT_W = 4;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WSETUP = 3'b001,
    ST_WPULSE = 3'b010,
    ST_WEND = 3'b011,
    ST_READ = 3'b100,
    ST_RELEASE = 3'b101,
    ST_RETAIN = 3'b110,
    ST_RECOVER = 3'b111
  } sramc_state_t;

endpackage

// File: design/sramc_sync.sv
`timescale 1ns/1ns
`default_nettype none

module sramc_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule

`default_nettype wire

// File: design/sramc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE_01: Memory holds 262,144 sixteen-bit words, 18-bit address, shared 16-bit bus.
// RULE_02: Chip select high or both lanes high puts the memory in standby.
// RULE_03: Read with both lanes low returns all sixteen bits.
// RULE_04: Read with only low lane returns bits 0 to 7.
// RULE_05: Read with only high lane returns bits 8 to 15.
// RULE_06: Write with both lanes low stores all sixteen bits.
// RULE_07: Write with only low lane updates bits 0 to 7.
// RULE_08: Write with only high lane updates bits 8 to 15.
// RULE_09: Output enable high keeps the memory off the bus.
// RULE_10: Write is active only while select, write enable and a lane are low.
// RULE_11: Write starts at last falling strobe, ends at first rising strobe.
// RULE_12: Active write interval lasts at least 40 ns.
// RULE_13: Write cycle at least 55 ns; address and selects valid 50 ns before end.
// RULE_14: Write data valid 25 ns before write end; zero hold.
// RULE_15: Address valid no later than write start.
// RULE_16: Read data valid 55 ns after address, select or lane; cycle at least 55 ns.
// RULE_17: Read data valid 30 ns after output enable falls.
// RULE_18: Previous read data holds 10 ns after an address change.
// RULE_19: Memory releases bus within 20 ns of write enable falling.
// RULE_20: Memory turns its outputs off faster than on.
// RULE_21: Retention by chip select high lets other pins float.
// RULE_22: Retention by lanes keeps both lanes high and chip select low.
// RULE_23: Deselect by retention start; wait one read cycle before next access.
// RULE_24: Storage changes only during an active write.
module sramc_ctrl
  import sramc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // User request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [1:0] reqByteEn,
  input wire logic [DATA_W-1:0] reqWdata,
  // User response
  output logic rspValid,
  output logic [DATA_W-1:0] rspRdata,
  // Retention control
  input wire logic retainReq,
  input wire logic retainByLanes,
  output logic retainActive,
  // Memory pins
  output logic [ADDR_W-1:0] word_address,
  output logic chipSelectN,
  output logic writeEnableN,
  output logic outputEnableN,
  output logic low_lane_select_n,
  output logic high_lane_select_n,
  // Shared data bus, split three ways
  input wire logic [DATA_W-1:0] sharedDataIn,
  output logic [DATA_W-1:0] sharedDataOut,
  output logic sharedDataOe
);

  localparam logic [CNT_W-1:0] WE_LOW_CNT = CNT_W'(WE_LOW_CYC);
  localparam logic [CNT_W-1:0] READ_WAIT_CNT = CNT_W'(READ_WAIT_CYC);
  localparam logic [CNT_W-1:0] RECOVERY_CNT = CNT_W'(RECOVERY_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  sramc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [1:0] laneN_reg, laneN_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic rspValid_reg, rspValid_next;
  logic csN_reg, csN_next;
  logic weN_reg, weN_next;
  logic oeN_reg, oeN_next;
  logic drive_reg, drive_next;
  logic [DATA_W-1:0] syncData;
  logic [DATA_W-1:0] laneMask;

  // Bus input crosses into the clock domain
  sramc_sync #(
    .WIDTH(DATA_W)
  ) u_data_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn(sharedDataIn),
    .syncOut(syncData)
  );

  // RULE_03: Mask unselected lanes
  assign laneMask = {{LANE_W{~laneN_reg[1]}}, {LANE_W{~laneN_reg[0]}}};

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    laneN_next = laneN_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rspValid_next = 1'b0;
    csN_next = csN_reg;
    weN_next = weN_reg;
    oeN_next = oeN_reg;
    drive_next = drive_reg;
    case (state_reg)
      ST_IDLE:
      begin
        // RULE_02: Idle is standby
        csN_next = 1'b1;
        weN_next = 1'b1;
        oeN_next = 1'b1;
        drive_next = 1'b0;
        laneN_next = 2'b11;
        if (retainReq)
        begin
          // RULE_23: Deselect at retention start
          state_next = ST_RETAIN;
          // RULE_22: Lane retention holds select low
          csN_next = ~retainByLanes;
        end
        else if (reqValid)
        begin
          // RULE_15: Address set before write start
          addr_next = reqAddr;
          laneN_next = ~reqByteEn;
          csN_next = 1'b0;
          if (reqWrite)
          begin
            // RULE_14: Data driven ahead of strobe
            wdata_next = reqWdata;
            drive_next = 1'b1;
            state_next = ST_WSETUP;
          end
          else
          begin
            // RULE_17: Output enable with address
            oeN_next = 1'b0;
            cnt_next = READ_WAIT_CNT;
            state_next = ST_READ;
          end
        end
      end
      ST_WSETUP:
      begin
        // RULE_11: Write enable falls last
        weN_next = 1'b0;
        cnt_next = WE_LOW_CNT;
        state_next = ST_WPULSE;
      end
      ST_WPULSE:
      begin
        // RULE_12: Hold pulse width
        if (cnt_reg == CNT_ONE)
        begin
          // RULE_11: Write enable rises first
          weN_next = 1'b1;
          state_next = ST_WEND;
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      ST_WEND:
      begin
        // RULE_13: Selects and address held past write end
        csN_next = 1'b1;
        laneN_next = 2'b11;
        drive_next = 1'b0;
        rspValid_next = 1'b1;
        state_next = ST_IDLE;
      end
      ST_READ:
      begin
        // RULE_16: Wait access time plus synchroniser
        if (cnt_reg == CNT_ONE)
        begin
          // RULE_04: Keep only selected lanes
          rdata_next = syncData & laneMask;
          rspValid_next = 1'b1;
          oeN_next = 1'b1;
          csN_next = 1'b1;
          laneN_next = 2'b11;
          state_next = ST_RELEASE;
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      ST_RELEASE:
      begin
        // RULE_20: Turnaround so memory leaves the bus
        state_next = ST_IDLE;
      end
      ST_RETAIN:
      begin
        // RULE_21: Other pins held inactive
        if (!retainReq)
        begin
          csN_next = 1'b1;
          laneN_next = 2'b11;
          cnt_next = RECOVERY_CNT;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        // RULE_23: Recovery wait before access
        if (cnt_reg == CNT_ONE)
        begin
          state_next = ST_IDLE;
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      addr_reg <= '0;
      laneN_reg <= 2'b11;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rspValid_reg <= 1'b0;
      csN_reg <= 1'b1;
      weN_reg <= 1'b1;
      oeN_reg <= 1'b1;
      drive_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      laneN_reg <= laneN_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rspValid_reg <= rspValid_next;
      csN_reg <= csN_next;
      weN_reg <= weN_next;
      oeN_reg <= oeN_next;
      drive_reg <= drive_next;
    end
  end

  assign reqReady = (state_reg == ST_IDLE) && !retainReq;
  assign rspValid = rspValid_reg;
  assign rspRdata = rdata_reg;
  assign retainActive = (state_reg == ST_RETAIN);
  assign word_address = addr_reg;
  assign chipSelectN = csN_reg;
  assign writeEnableN = weN_reg;
  assign outputEnableN = oeN_reg;
  assign low_lane_select_n = laneN_reg[0];
  assign high_lane_select_n = laneN_reg[1];
  assign sharedDataOut = wdata_reg;
  assign sharedDataOe = drive_reg;

endmodule

`default_nettype wire

// File: verif/sramc_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sramc_ctrl_checker
  import sramc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // User side
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic reqWrite,
  input wire logic rspValid,
  input wire logic retainActive,
  // Memory pins
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic chipSelectN,
  input wire logic writeEnableN,
  input wire logic outputEnableN,
  input wire logic low_lane_select_n,
  input wire logic high_lane_select_n,
  input wire logic [DATA_W-1:0] sharedDataOut,
  input wire logic sharedDataOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_we_pulse;
    !writeEnableN ##1 writeEnableN;
  endsequence
  sequence s_read_open;
    !outputEnableN && !chipSelectN;
  endsequence
  a_we_pulse_len: assert property ($fell(writeEnableN) |-> s_we_pulse)
    else $error("write pulse not one cycle");
  a_write_setup: assert property ($fell(writeEnableN) |-> !$past(chipSelectN) && sharedDataOe)
    else $error("select or data late at write start");
  a_write_hold_end: assert property ($rose(writeEnableN) |-> $stable(word_address) &&
    $stable(sharedDataOut) && $stable(low_lane_select_n) && !chipSelectN)
    else $error("address or data moved at write end");
  a_write_resp_time: assert property (reqValid && reqReady && reqWrite |-> ##[4:5] rspValid)
    else $error("write response late");
  a_read_resp_time: assert property (reqValid && reqReady && !reqWrite |=> s_read_open ##[3:4] rspValid)
    else $error("read not opened or answered");
  a_drive_excl: assert property (!outputEnableN |-> !sharedDataOe && writeEnableN)
    else $error("controller drives during read");
  a_retain_pins: assert property (retainActive |-> low_lane_select_n && high_lane_select_n &&
    writeEnableN && !sharedDataOe && !reqReady)
    else $error("retention pins wrong");
  a_recover_wait: assert property ($fell(retainActive) |-> !reqReady && chipSelectN)
    else $error("access too soon after retention");
endmodule
bind sramc_ctrl sramc_ctrl_checker chk_inst (.sys_clk, .rst, .reqValid, .reqReady, .reqWrite,
  .rspValid, .retainActive, .word_address, .chipSelectN, .writeEnableN, .outputEnableN,
  .low_lane_select_n, .high_lane_select_n, .sharedDataOut, .sharedDataOe);
`default_nettype wire

// File: verif/sramc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module sramc_mem_model
  import sramc_pkg::*;
(
  // Memory pins
  input wire logic [17:0] wordAddress,
  input wire logic csN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic loLaneN,
  input wire logic hiLaneN,
  // Controller side of the bus
  input wire logic [15:0] ctrlData,
  input wire logic ctrlOe,
  output logic [15:0] busLevel
);
  logic [15:0] mem [0:WORD_COUNT-1];
  logic [15:0] word;
  logic [15:0] rdWord;
  logic flt;
  logic act;
  logic rdLo;
  logic rdHi;
  logic rdValid = 1'b1;
  logic wrOpen;
  logic [17:0] wrAddr;
  logic [15:0] wrData;
  logic [1:0] wrLane;
  initial
  begin
    for (int i = 0; i < WORD_COUNT; i++)
      mem[i] = 16'h0000;
  end
  // Undriven lanes wander instead of holding
  initial
  begin
    flt = 1'b0;
    forever #50 flt = ~flt;
  end
  assign act = !csN && !(loLaneN && hiLaneN);
  assign rdLo = act && weN && !oeN && !loLaneN;
  assign rdHi = act && weN && !oeN && !hiLaneN;
  // data goes bad after the hold, settles after the access time
  always @(wordAddress or csN or oeN or loLaneN or hiLaneN)
  begin
    rdValid <= #(READ_HOLD_MIN_NS) 1'b0;
    rdValid <= #(ADDR_ACCESS_MAX_NS) 1'b1;
  end
  always @*
  begin
    word = mem[wordAddress];
    rdWord = rdValid ? word : ~word;
    busLevel[7:0] = ctrlOe ? ctrlData[7:0] : (rdLo ? rdWord[7:0] : {8{flt}});
    busLevel[15:8] = ctrlOe ? ctrlData[15:8] : (rdHi ? rdWord[15:8] : {8{flt}});
  end
  // write open while select, write enable and a lane are low
  assign wrOpen = act && !weN;
  always @*
  begin
    if (wrOpen)
    begin
      wrAddr = wordAddress;
      wrData = busLevel;
      wrLane = {!hiLaneN, !loLaneN};
    end
  end
  // selected lanes stored at write end
  always @(negedge wrOpen)
  begin
    if (wrLane[0] === 1'b1)
      mem[wrAddr][7:0] = wrData[7:0];
    if (wrLane[1] === 1'b1)
      mem[wrAddr][15:8] = wrData[15:8];
  end
endmodule
`default_nettype wire

// File: verif/tb_async_sram_16bit_byte_lanes.sv
`timescale 1ns/1ns
`default_nettype none
module tb_async_sram_16bit_byte_lanes;
  import sramc_pkg::*;
  logic sys_clk, rst, reqValid, reqReady, reqWrite, rspValid;
  logic retainReq, retainByLanes, retainActive, csN, weN, oeN, loLaneN, hiLaneN, ctrlOe;
  logic [ADDR_W-1:0] reqAddr, wordAddress;
  logic [1:0] reqByteEn;
  logic [DATA_W-1:0] reqWdata, rspRdata, busLevel, ctrlData, q;
  int errorCnt = 0;
  int nCompared = 0;
  sramc_ctrl sramc_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqByteEn(reqByteEn),
    .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata), .retainReq(retainReq),
    .retainByLanes(retainByLanes), .retainActive(retainActive), .word_address(wordAddress),
    .chipSelectN(csN), .writeEnableN(weN), .outputEnableN(oeN), .low_lane_select_n(loLaneN),
    .high_lane_select_n(hiLaneN), .sharedDataIn(busLevel), .sharedDataOut(ctrlData),
    .sharedDataOe(ctrlOe));
  sramc_mem_model sramc_mem_model_inst (.wordAddress(wordAddress), .csN(csN), .weN(weN),
    .oeN(oeN), .loLaneN(loLaneN), .hiLaneN(hiLaneN), .ctrlData(ctrlData), .ctrlOe(ctrlOe),
    .busLevel(busLevel));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic closeOut;
    $display("Compared %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    nCompared++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic pickSig(input int sel);
    return (sel == 0) ? reqReady : ((sel == 1) ? rspValid : retainActive);
  endfunction
  task automatic waitHi(input int sel, input string msg);
    int n;
    n = 0;
    while (pickSig(sel) !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (pickSig(sel) !== 1'b1)
    begin
      errorCnt++;
      $display("CHECK FAILED at %0t: timeout on %s", $time, msg);
      closeOut();
    end
  endtask
  task automatic doReq(input logic w, input logic [17:0] a, input logic [1:0] be,
    input logic [15:0] d);
    reqWrite = w;
    reqAddr = a;
    reqByteEn = be;
    reqWdata = d;
    reqValid = 1'b1;
    waitHi(0, "ready");
    @(negedge sys_clk);
    reqValid = 1'b0;
    waitHi(1, "response");
    q = rspRdata;
    @(negedge sys_clk);
  endtask
  task automatic tWord;
    doReq(1'b1, 18'h3FFFF, 2'b11, 16'hA55A);
    doReq(1'b1, 18'h00000, 2'b11, 16'h5AA5);
    doReq(1'b0, 18'h3FFFF, 2'b11, 16'h0000);
    chk(q, 16'hA55A, "top word");
    doReq(1'b0, 18'h00000, 2'b11, 16'h0000);
    chk(q, 16'h5AA5, "bottom word");
    $display("Test word done");
  endtask
  task automatic tLanes;
    doReq(1'b1, 18'h00005, 2'b11, 16'h1234);
    doReq(1'b1, 18'h00005, 2'b01, 16'hFFAB);
    doReq(1'b1, 18'h00005, 2'b10, 16'hCDFF);
    doReq(1'b0, 18'h00005, 2'b11, 16'h0000);
    chk(q, 16'hCDAB, "lane merge");
    doReq(1'b0, 18'h00005, 2'b01, 16'h0000);
    chk(q, 16'h00AB, "low lane read");
    doReq(1'b0, 18'h00005, 2'b10, 16'h0000);
    chk(q, 16'hCD00, "high lane read");
    $display("Test lanes done");
  endtask
  task automatic tStandby;
    doReq(1'b1, 18'h00005, 2'b00, 16'h0F0F);
    doReq(1'b0, 18'h00005, 2'b11, 16'h0000);
    chk(q, 16'hCDAB, "standby write");
    $display("Test standby done");
  endtask
  task automatic tRetain(input logic byLanes);
    retainByLanes = byLanes;
    retainReq = 1'b1;
    waitHi(2, "retention");
    @(negedge sys_clk);
    chk({13'h0000, reqReady, loLaneN, hiLaneN}, {13'h0000, 3'b011}, "lanes in retention");
    chk({15'h0000, csN}, {15'h0000, ~byLanes}, "select in retention");
    retainReq = 1'b0;
    doReq(1'b0, 18'h00005, 2'b11, 16'h0000);
    chk(q, 16'hCDAB, "after retention");
    $display("Test retention done");
  endtask
  initial
  begin
    rst = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqByteEn = 2'b00;
    reqWdata = '0;
    retainReq = 1'b0;
    retainByLanes = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    tWord();
    tLanes();
    tStandby();
    tRetain(1'b0);
    tRetain(1'b1);
    closeOut();
  end
endmodule
`default_nettype wire
